// >>> stp_pkg.sv
// shared constants for the status pin strap and interrupt block
package stp_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_PULSE_NS  = 10;
  // least time, so round up, never below one cycle
  localparam int POR_CYC_I     = (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] POR_CYC = 4'((POR_CYC_I < 1) ? 1 : POR_CYC_I);

  // ------------------------------------------------------------------
  // sizes and defaults
  // ------------------------------------------------------------------
  localparam int NUM_PINS  = 4;
  localparam int NUM_FLAGS = 6;
  localparam logic [5:0] MULT_DEFAULT = 6'h28;   // multiplier of 40
  localparam logic [5:0] MULT_DIRECT  = 6'h00;   // multiplier bypassed
  // flags watched in the rising direction only (bit 0: estimate done)
  localparam logic [5:0] RISE_ONLY    = 6'h01;

  // start-up tuning words, entry 0 first from the right
  localparam logic [7:0][15:0] STARTUP_ROM = {
    16'h27D0, 16'h1F75, 16'h1797, 16'h13E8,
    16'h0FBA, 16'h0D45, 16'h09F4, 16'h0000
  };

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_STRAP      = 8'h04;
  localparam logic [7:0] OFF_FIRST_TUNING_WORD = 8'h08;
  localparam logic [7:0] OFF_PIN_SEL    = 8'h0C;
  localparam logic [7:0] OFF_STATUS     = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;

  // field positions
  localparam int CTRL_IRQ_RESET  = 0;
  localparam int CTRL_LOOP_CLOSE = 1;
  localparam int PIN_SEL_STRIDE  = 8;
  localparam int PIN_SEL_IRQ     = 6;
  localparam logic [31:0] PIN_SEL_MASK = 32'h7F7F7F7F;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : stp_pkg

// >>> stp_irq_if.sv
// carrier between the pin top and the interrupt detector
`timescale 1ns/10ps
`default_nettype none

interface stp_irq_if;
  logic [5:0] flags;
  logic [5:0] mask;
  logic       clear;
  logic       irq;
  logic [5:0] irq_status;

  modport top (output flags, output mask, output clear, input irq, input irq_status);
  modport det (input flags, input mask, input clear, output irq, output irq_status);
endinterface : stp_irq_if

`default_nettype wire

// >>> stp_irq.sv
// change detector, interrupt latch and cause snapshot
`timescale 1ns/10ps
`default_nettype none

module stp_irq #(
  parameter logic [5:0] RISE_MASK = stp_pkg::RISE_ONLY
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link to the top
  stp_irq_if.det   bus
);

  typedef struct packed {
    logic [5:0] prev;
    logic       irq;
    logic [5:0] irq_status;
  } stp_irq_s;

  stp_irq_s   s_q;
  stp_irq_s   s_d;
  logic [5:0] ev;

  // ------------------------------------------------------------------
  // detection
  // ------------------------------------------------------------------
  // edge seen, rise-only flags ignore falls, then masked
  assign ev = (bus.flags ^ s_q.prev) & (bus.flags | ~RISE_MASK) & bus.mask; // RULE13 RULE14

  // next state; a new event beats a clear in the same cycle
  always_comb begin
    s_d      = s_q;
    s_d.prev = bus.flags;                 // RULE16
    if (bus.clear) begin
      s_d.irq        = 1'b0;              // RULE16
      s_d.irq_status = 6'h00;
    end
    if (|ev) begin
      s_d.irq = 1'b1;                     // RULE14
      if (!s_q.irq || bus.clear) begin
        s_d.irq_status = bus.flags;       // RULE15
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.irq        = s_q.irq;
  assign bus.irq_status = s_q.irq_status;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_event_sets_irq: assert property (|ev |=> bus.irq) // RULE14
    else $error("unmasked event did not raise irq");
  a_snapshot_cause: assert property ($rose(bus.irq) |-> bus.irq_status == $past(bus.flags)) // RULE15
    else $error("irq status is not the snapshot of the flags");
  a_clear_rearms: assert property (bus.clear && !(|ev) |=> !bus.irq && bus.irq_status == 6'h00) // RULE16
    else $error("irq reset did not clear flag and status");
  a_fall_ignored: assert property (
      !bus.irq && !bus.clear && ((bus.flags ^ s_q.prev) & ~RISE_MASK) == 6'h00
      && (bus.flags & (bus.flags ^ s_q.prev)) == 6'h00 |=> !bus.irq) // RULE13
    else $error("fall on rise-only flag raised irq");
  a_masked_quiet: assert property (!bus.irq && bus.mask == 6'h00 |=> !bus.irq) // RULE14
    else $error("irq raised with all events masked");

  c_irq_raised: cover property ($rose(bus.irq));
  c_irq_cleared: cover property (bus.irq ##1 bus.clear ##1 !bus.irq);

endmodule : stp_irq

`default_nettype wire

// >>> stp_top.sv
// status pins: strap capture at reset, start-up tuning word, status and irq outputs
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// RULE1: short internal pulse after power-up, pins float
// RULE2: pin levels latched as strap at pulse end
// RULE3: same edge returns pins to driving outputs
// RULE4: external reset repeats strap capture and release
// RULE5: eight sixteen-bit start words, low strap selects
// RULE6: chosen word loads first tuning register directly
// RULE7: top strap bit picks multiplier or direct
// RULE8: table spans zero to top frequency linearly; the code table rises in uneven steps
// RULE9: multiplier mode starts with factor forty
// RULE10: host closes loop only after programming it
// RULE11: any pin may carry the irq flag
// RULE12: status flags readable at any time
// RULE13: flags watched for changes, some one-way
// RULE14: masked change sets latch, irq active high
// RULE15: irq assertion snapshots status into irq status
// RULE16: irq reset clears flag, snapshot, rearms detection
// RULE17: host applies reset pulse after supplies good
// RULE18: external reset acts on its falling edge
// RULE19: external reset high floats pins at once
// RULE20: each pin ORs its selected status indications
// RULE21: strap holds from one reset to next
module stp_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // external reset pin, active high
  input  wire logic              ext_reset,
  // status pins
  input  wire logic [3:0]        status_pin_in,
  output logic      [3:0]        status_pin_out,
  output logic      [3:0]        status_pin_oe,
  // internal status indications
  input  wire logic [5:0]        status_flags,
  // start-up results
  output logic      [15:0]       first_tuning_word_register,
  output logic                   system_sample_clock_direct,
  output logic      [5:0]        system_sample_clock_mult,
  output logic                   loop_close,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  typedef struct packed {
    logic [3:0]  por_cnt;
    logic        rst_prev;
    logic [3:0]  strap;
    logic [15:0] tune_word;
    logic [5:0]  mult;
    logic        loop_close;
    logic [31:0] pin_sel;
    logic [5:0]  mask;
    logic        irq_clr;
    logic [3:0]  pin_out;
    logic        aw_have;
    logic [7:0]  awaddr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } stp_top_s;

  stp_top_s   s_q;
  stp_top_s   s_d;
  logic       in_reset;
  logic       rst_fall;
  logic [3:0] pin_func;
  stp_irq_if  irq_bus ();

  // ------------------------------------------------------------------
  // reset pulse and pin direction
  // ------------------------------------------------------------------
  // pins float while the pulse runs or the reset pin is high; the pin
  // term is combinational so release to high impedance needs no edge
  assign in_reset      = (s_q.por_cnt != 4'h0) || ext_reset;  // RULE1 RULE19
  assign rst_fall      = s_q.rst_prev && !in_reset;           // RULE18
  assign status_pin_oe = in_reset ? 4'h0 : 4'hF;              // RULE3 RULE19

  // ------------------------------------------------------------------
  // pin functions
  // ------------------------------------------------------------------
  // one OR term per pin over its selected flags, plus the irq option
  generate
    for (genvar n = 0; n < stp_pkg::NUM_PINS; n++) begin : g_pin
      assign pin_func[n] =
        |(status_flags & s_q.pin_sel[n*stp_pkg::PIN_SEL_STRIDE +: 6])          // RULE20
        | (s_q.pin_sel[n*stp_pkg::PIN_SEL_STRIDE + stp_pkg::PIN_SEL_IRQ]
           & irq_bus.irq);                                                     // RULE11
    end
  endgenerate

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // next state: strap, bus slave, pins
  // ------------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic [7:0]  ra;
    wv            = 32'h0;
    ra            = 8'(s_axi_araddr);
    s_d           = s_q;
    s_d.irq_clr   = 1'b0;
    s_d.rst_prev  = in_reset;
    s_d.pin_out   = pin_func;
    if (s_q.por_cnt != 4'h0) begin
      s_d.por_cnt = s_q.por_cnt - 4'h1;
    end
    // write address and data accepted in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr  = 8'(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end
    // commit once both halves are held
    if (s_q.aw_have && s_q.w_have) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = stp_pkg::RESP_OKAY;
      if (s_q.awaddr == stp_pkg::OFF_CTRL) begin
        wv = merge({30'h0, s_q.loop_close, 1'b0}, s_q.wdata, s_q.wstrb);
        s_d.irq_clr    = wv[stp_pkg::CTRL_IRQ_RESET];                         // RULE16
        s_d.loop_close = wv[stp_pkg::CTRL_LOOP_CLOSE];
      end else if (s_q.awaddr == stp_pkg::OFF_FIRST_TUNING_WORD) begin
        wv = merge({16'h0, s_q.tune_word}, s_q.wdata, s_q.wstrb);
        s_d.tune_word = wv[15:0];
      end else if (s_q.awaddr == stp_pkg::OFF_PIN_SEL) begin
        s_d.pin_sel = merge(s_q.pin_sel, s_q.wdata, s_q.wstrb) & stp_pkg::PIN_SEL_MASK;
      end else if (s_q.awaddr == stp_pkg::OFF_IRQ_MASK) begin
        wv = merge({26'h0, s_q.mask}, s_q.wdata, s_q.wstrb);
        s_d.mask = wv[5:0];
      end else if (s_q.awaddr == stp_pkg::OFF_STRAP || s_q.awaddr == stp_pkg::OFF_STATUS
                   || s_q.awaddr == stp_pkg::OFF_IRQ_STATUS) begin
        s_d.bresp = stp_pkg::RESP_OKAY;   // read-only, write dropped
      end else begin
        s_d.bresp = stp_pkg::RESP_DECERR;
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // read: data taken at the address handshake
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = stp_pkg::RESP_OKAY;
      if (ra == stp_pkg::OFF_CTRL) begin
        s_d.rdata = {30'h0, s_q.loop_close, 1'b0};
      end else if (ra == stp_pkg::OFF_STRAP) begin
        s_d.rdata = {18'h0, s_q.mult, 3'h0, s_q.strap[3], s_q.strap};
      end else if (ra == stp_pkg::OFF_FIRST_TUNING_WORD) begin
        s_d.rdata = {16'h0, s_q.tune_word};
      end else if (ra == stp_pkg::OFF_PIN_SEL) begin
        s_d.rdata = s_q.pin_sel;
      end else if (ra == stp_pkg::OFF_STATUS) begin
        s_d.rdata = {26'h0, status_flags};                                    // RULE12
      end else if (ra == stp_pkg::OFF_IRQ_MASK) begin
        s_d.rdata = {26'h0, s_q.mask};
      end else if (ra == stp_pkg::OFF_IRQ_STATUS) begin
        s_d.rdata = {26'h0, irq_bus.irq_status};
      end else begin
        s_d.rdata = 32'h0;
        s_d.rresp = stp_pkg::RESP_DECERR;
      end
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // strap follows the pins through reset, frozen from the release on
    if (in_reset) begin
      s_d.strap = status_pin_in;                                              // RULE2 RULE4 RULE21
    end
    // start-up load beats a bus write landing on the same edge
    if (rst_fall) begin
      s_d.tune_word  = stp_pkg::STARTUP_ROM[s_q.strap[2:0]];                  // RULE5 RULE6 RULE8
      s_d.mult       = s_q.strap[3] ? stp_pkg::MULT_DIRECT : stp_pkg::MULT_DEFAULT; // RULE7 RULE9
      s_d.loop_close = 1'b0;                                                  // RULE10
    end
  end

  // state register; reset loads the pulse count so pins float meanwhile
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q         <= '0;
      s_q.por_cnt <= stp_pkg::POR_CYC;
      s_q.rst_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // interrupt detector
  // ------------------------------------------------------------------
  assign irq_bus.flags = status_flags;
  assign irq_bus.mask  = s_q.mask;
  assign irq_bus.clear = s_q.irq_clr;

  stp_irq #(
    .RISE_MASK (stp_pkg::RISE_ONLY)
  ) u_irq (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (irq_bus.det)
  );

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign status_pin_out             = s_q.pin_out;
  assign first_tuning_word_register = s_q.tune_word;
  assign system_sample_clock_direct = s_q.strap[3];                          // RULE7
  assign system_sample_clock_mult   = s_q.mult;
  assign loop_close                 = s_q.loop_close;
  assign s_axi_awready              = !s_q.aw_have && !s_q.bvalid;
  assign s_axi_wready               = !s_q.w_have && !s_q.bvalid;
  assign s_axi_bvalid               = s_q.bvalid;
  assign s_axi_bresp                = s_q.bresp;
  assign s_axi_arready              = !s_q.rvalid;
  assign s_axi_rvalid               = s_q.rvalid;
  assign s_axi_rdata                = s_q.rdata;
  assign s_axi_rresp                = s_q.rresp;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pulse_floats: assert property (s_q.por_cnt != 4'h0 |-> status_pin_oe == 4'h0) // RULE1
    else $error("pins driven during internal reset pulse");
  a_pulse_ends: assert property ($rose(aresetn) |-> ##1 s_q.por_cnt == 4'h0) // RULE1
    else $error("internal reset pulse too long");
  a_strap_latch: assert property (rst_fall |-> s_q.strap == $past(status_pin_in)) // RULE2
    else $error("strap not latched from pins");
  a_pins_return: assert property (rst_fall |-> status_pin_oe == 4'hF) // RULE3
    else $error("pins not driven after reset release");
  a_ext_repeats: assert property ($fell(ext_reset) && s_q.por_cnt == 4'h0
                                  |-> rst_fall ##1 first_tuning_word_register
                                  == stp_pkg::STARTUP_ROM[$past(s_q.strap[2:0])]) // RULE4
    else $error("external reset did not repeat start-up load");
  a_ftw_loaded: assert property (rst_fall |=> first_tuning_word_register
                                 == stp_pkg::STARTUP_ROM[$past(s_q.strap[2:0])]) // RULE6
    else $error("start-up word not loaded");
  a_mult_default: assert property (rst_fall && !s_q.strap[3]
                                   |=> system_sample_clock_mult == stp_pkg::MULT_DEFAULT) // RULE9
    else $error("multiplier not forty in multiplier mode");
  a_mode_direct: assert property (rst_fall && s_q.strap[3] |=> system_sample_clock_direct
                                  && system_sample_clock_mult == stp_pkg::MULT_DIRECT) // RULE7
    else $error("direct clock mode not selected");
  a_ext_floats: assert property (ext_reset |-> status_pin_oe == 4'h0) // RULE19
    else $error("pins driven while external reset high");
  a_strap_holds: assert property (!in_reset && !$past(in_reset) |-> $stable(s_q.strap)) // RULE21
    else $error("strap changed outside reset");
  a_pin_or: assert property (##1 status_pin_out[0] == (|($past(status_flags)
                             & $past(s_q.pin_sel[5:0])) | ($past(s_q.pin_sel[6])
                             & $past(irq_bus.irq)))) // RULE20
    else $error("pin zero is not the OR of its selection");
  a_loop_open: assert property (rst_fall |=> !loop_close) // RULE10
    else $error("loop closed after strapped start-up");

  c_strap_fall: cover property (ext_reset ##1 !ext_reset ##1 status_pin_oe == 4'hF);
  c_irq_on_pin: cover property (s_q.pin_sel[6] && irq_bus.irq ##1 status_pin_out[0]);
  c_bus_write: cover property (s_axi_bvalid && s_axi_bready);

endmodule : stp_top

`default_nettype wire

// >>> stp_top_unused_guard.sv
// intentionally empty of logic: no additional modules
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> stp_strap_model.sv
// strap resistors on the four status pins, seen from outside the block
`timescale 1ns/10ps
`default_nettype none

module stp_strap_model (
  // resistor pattern, one pull per pin
  input  wire logic [3:0] strap,
  // block side of the pins
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  // level seen on each wire
  output logic      [3:0] pin_level
);
  // a released pin falls to its pull, so no stale value survives
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : strap[i];
    end
  end
endmodule // stp_strap_model

`default_nettype wire

// >>> stp_top_tb_top.sv
// self-checking bench for the status pin strap and irq block
`timescale 1ns/10ps
`default_nettype none

module stp_top_tb_top;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic        aclk, aresetn, ext_reset;
  logic [3:0]  strap, pin_in, pin_out, pin_oe;
  logic [5:0]  flags, mult;
  logic [15:0] tword;
  logic        direct, loop_close;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, rsp;
  int          err_total, n_tests;

  stp_strap_model i_stp_strap_model (.strap(strap), .pin_out(pin_out), .pin_oe(pin_oe),
                                     .pin_level(pin_in));

  stp_top i_stp_top (
    .aclk(aclk), .aresetn(aresetn), .ext_reset(ext_reset),
    .status_pin_in(pin_in), .status_pin_out(pin_out), .status_pin_oe(pin_oe),
    .status_flags(flags), .first_tuning_word_register(tword),
    .system_sample_clock_direct(direct), .system_sample_clock_mult(mult),
    .loop_close(loop_close),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ------------------------------------------------------------------
  // clock, checks, bus tasks
  // ------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // both halves offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rsp);
    chk(rd, exp);
    chk(32'(rsp), 32'(stp_pkg::RESP_OKAY));
  endtask

  // strap pattern p must show up in every start-up output
  task automatic strap_chk(input logic [3:0] p);
    logic [5:0] m;
    m = p[3] ? 6'h00 : 6'h28;
    chk(32'(pin_oe), 32'hF);
    chk(32'(tword), 32'(stp_pkg::STARTUP_ROM[p[2:0]]));
    chk(32'(direct), 32'(p[3]));
    chk(32'(mult), 32'(m));
    rd_chk(stp_pkg::OFF_STRAP, {18'h0, m, 3'h0, p[3], p});
  endtask

  // ------------------------------------------------------------------
  // watchdog: the whole sequence needs well under 3000 cycles
  // ------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    results();
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    aresetn = 1'b0; ext_reset = 1'b0; strap = 4'h5; flags = 6'h00;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    err_total = 0; n_tests = 0;
    repeat (11) @(posedge aclk);
    #1 chk(32'(pin_oe), 32'h0);
    @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    strap_chk(4'h5);
    // table ends: zero and the top frequency at 1 GHz
    chk(32'(stp_pkg::STARTUP_ROM[0]), 32'h0);
    chk(32'(stp_pkg::STARTUP_ROM[7]), 32'(int'(155.51758e6 / 1.0e9 * 65536.0)));
    // host programs the word before it closes the loop
    axi_wr(stp_pkg::OFF_FIRST_TUNING_WORD, 32'h0000_1234, rsp);
    chk(32'(rsp), 32'(stp_pkg::RESP_OKAY));
    rd_chk(stp_pkg::OFF_FIRST_TUNING_WORD, 32'h0000_1234);
    axi_wr(stp_pkg::OFF_CTRL, 32'h2, rsp);
    chk(32'(loop_close), 32'h1);
    rd_chk(stp_pkg::OFF_CTRL, 32'h2);
    axi_rd(8'h1C, rd, rsp);
    chk(32'(rsp), 32'(stp_pkg::RESP_DECERR));
    chk(rd, 32'h0);
    axi_wr(8'h20, 32'h1, rsp);
    chk(32'(rsp), 32'(stp_pkg::RESP_DECERR));
    // every pattern through the external reset pin
    for (int p = 0; p < 16; p++) begin
      @(posedge aclk);
      strap <= 4'(p);
      ext_reset <= 1'b1;
      #1 chk(32'(pin_oe), 32'h0);
      repeat (8) @(posedge aclk);
      ext_reset <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(32'(loop_close), 32'h0);
      strap_chk(4'(p));
    end
    // pin 0 ors flags 1 and 2, pin 3 carries the irq
    axi_wr(stp_pkg::OFF_PIN_SEL, 32'h4000_0006, rsp);
    rd_chk(stp_pkg::OFF_PIN_SEL, 32'h4000_0006);
    axi_wr(stp_pkg::OFF_IRQ_MASK, 32'h01, rsp);
    flags <= 6'h01;
    repeat (4) @(posedge aclk);
    chk(32'(pin_out[3]), 32'h1);
    rd_chk(stp_pkg::OFF_IRQ_STATUS, 32'h01);
    rd_chk(stp_pkg::OFF_STATUS, 32'h01);
    axi_wr(stp_pkg::OFF_CTRL, 32'h1, rsp);
    repeat (3) @(posedge aclk);
    chk(32'(pin_out[3]), 32'h0);
    rd_chk(stp_pkg::OFF_IRQ_STATUS, 32'h0);
    // estimate-done fall must not raise the irq
    flags <= 6'h00;
    repeat (4) @(posedge aclk);
    chk(32'(pin_out[3]), 32'h0);
    // masked change: no irq, but the pin or still follows
    flags <= 6'h04;
    repeat (4) @(posedge aclk);
    chk(32'(pin_out), 32'h1);
    axi_wr(stp_pkg::OFF_IRQ_MASK, 32'h04, rsp);
    flags <= 6'h00;
    repeat (4) @(posedge aclk);
    chk(32'(pin_out), 32'h8);
    axi_wr(stp_pkg::OFF_CTRL, 32'h1, rsp);
    repeat (3) @(posedge aclk);
    chk(32'(pin_out[3]), 32'h0);
    // a bus write to the strap register must leave it alone
    axi_wr(stp_pkg::OFF_STRAP, 32'h0, rsp);
    chk(32'(rsp), 32'(stp_pkg::RESP_OKAY));
    strap_chk(4'hF);
    results();
  end
endmodule // stp_top_tb_top

`default_nettype wire
